// ### design/sids_debounce.sv
`include "sids_defines.svh"

module sids_debounce #(
    parameter int TICKS = `SIDS_DEBOUNCE_US
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw,
    input  wire logic tick,
    input  wire logic bypass,
    output logic      stable
);
    import sids_pkg::*;

    localparam int CW = $clog2(TICKS + 1);

    generate
        if (TICKS < 1) begin : g_bad_ticks
            $error("sids_debounce: TICKS must be at least 1");
        end
    endgenerate

    logic          sync1_reg;
    logic          sync2_reg;
    logic          stable_reg;
    logic [CW-1:0] cnt_reg;

    wire differs  = sync2_reg != stable_reg;
    wire cnt_done = cnt_reg == CW'(TICKS - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= `SIDS_IDLE_LEVEL;
            sync2_reg <= `SIDS_IDLE_LEVEL;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Logic-level sources skip the filter; contacts must hold for the full window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_reg <= `SIDS_IDLE_LEVEL;
            cnt_reg    <= '0;
        end else if (bypass || !differs) begin
            stable_reg <= sync2_reg;
            cnt_reg    <= '0;
        end else if (tick) begin
            if (cnt_done) begin
                stable_reg <= sync2_reg;
                cnt_reg    <= '0;
            end else begin
                cnt_reg <= cnt_reg + CW'(1);
            end
        end
    end

    assign stable = stable_reg;

    property p_filter_holds;
        @(posedge clk) disable iff (!rst_n)
        (!bypass && differs && !tick) |=> $stable(stable_reg);
    endproperty
    a_filter_holds: assert property (p_filter_holds)
        else $error("debounced level moved without a tick");

    property p_bypass_follows;
        @(posedge clk) disable iff (!rst_n)
        (bypass && differs) |=> (stable_reg == $past(sync2_reg));
    endproperty
    a_bypass_follows: assert property (p_bypass_follows)
        else $error("logic-level input not passed straight through");

endmodule : sids_debounce

// ### design/sids_defines.svh
`ifndef SIDS_DEFINES_SVH
`define SIDS_DEFINES_SVH

// Signal polarity codes
`define SIDS_POL_LOW        2'h0
`define SIDS_POL_HIGH       2'h1
`define SIDS_POL_FALL       2'h2
`define SIDS_POL_RISE       2'h3

// Signal type codes
`define SIDS_TYPE_SWITCH    2'h0
`define SIDS_TYPE_3V3       2'h1
`define SIDS_TYPE_5V        2'h2

// Configuration values that enable single-key preset speed operation
`define SIDS_IN_TYPE_PROG   8'h04
`define SIDS_CTRL_PRESET    8'h05
`define SIDS_METHOD_SINGLE  8'h01

// Working mode codes
`define SIDS_MODE_DUTY      2'h0
`define SIDS_MODE_TORQUE    2'h1
`define SIDS_MODE_SPEED     2'h2
`define SIDS_MODE_POSITION  2'h3

// Timing
`define SIDS_CLK_NS         40
`define SIDS_TICK_NS        1000
`define SIDS_DEBOUNCE_US    10000
// Cycles after reset before the steppers may act
`define SIDS_WARM_CYCLES    3'h4

// Reset values
`define SIDS_IDLE_LEVEL     1'b1

`endif

// ### design/sids_pkg.sv
package sids_pkg;

    typedef enum logic [1:0] {
        SIDS_CMD_STOP = 2'b00,
        SIDS_CMD_FWD  = 2'b01,
        SIDS_CMD_REV  = 2'b10
    } sids_cmd_type;

    // Four-step cycle: first direction, stop, other direction, stop
    typedef enum logic [1:0] {
        SIDS_STEP_RUN_A  = 2'b00,
        SIDS_STEP_STOP_A = 2'b01,
        SIDS_STEP_RUN_B  = 2'b10,
        SIDS_STEP_STOP_B = 2'b11
    } sids_step_type;

endpackage : sids_pkg

// ### design/sids_sequencer.sv
// Functional notes
// - Control input sense comes from the polarity setting; low-level is one choice.
// - Low-level: first input cycles forward, stop, reverse, stop on its levels.
// - Low-level: second input cycles reverse, stop, forward, stop on its levels.
// - Falling-edge: each press-release of first input steps forward, stop, reverse, stop.
// - Falling-edge: each press-release of second input steps reverse, stop, forward, stop.
// - Edge modes latch the commanded state until the next qualifying edge.
// - High-level: first input cycles likewise with inverted sense.
// - Active halt input forces an immediate stop in every polarity mode.
// - Status line shows fault, or completion in position mode.
// - Signal type selects contact or logic-level handling, combined with polarity.
// - Polarity codes: 0 low, 1 high, 2 falling edge, 3 rising edge.
// - Active only for built-in program, preset speed and single contact settings.
`include "sids_defines.svh"

module sids_sequencer #(
    parameter int DEBOUNCE_US = `SIDS_DEBOUNCE_US
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       direction_input_one,
    input  wire logic       direction_input_two,
    input  wire logic       halt_input,
    input  wire logic [1:0] signal_polarity,
    input  wire logic [1:0] signal_type,
    input  wire logic [7:0] port_input_type,
    input  wire logic [7:0] port_control_type,
    input  wire logic [7:0] control_method,
    input  wire logic [1:0] working_mode,
    input  wire logic       drive_fault,
    input  wire logic       position_done,
    output logic            run_forward,
    output logic            run_reverse,
    output logic            emergency_stop,
    output logic            fault_or_done_output,
    output logic            single_key_active
);
    import sids_pkg::*;

    // One debounce tick per microsecond
    localparam int TICK_CYCLES = (`SIDS_TICK_NS + `SIDS_CLK_NS - 1) / `SIDS_CLK_NS;
    localparam int TICK_W      = $clog2(TICK_CYCLES);

    generate
        if (DEBOUNCE_US < 1) begin : g_bad_debounce
            $error("sids_sequencer: DEBOUNCE_US must be at least 1");
        end
        if (TICK_CYCLES < 2) begin : g_bad_tick
            $error("sids_sequencer: tick divider needs at least two cycles");
        end
    endgenerate

    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick_reg;
    logic              deb_one;
    logic              deb_two;
    logic              deb_halt;
    sids_step_type     step_one;
    sids_step_type     step_two;
    logic              adv_one;
    logic              adv_two;
    logic              last_two_reg;
    logic              run_forward_reg;
    logic              run_reverse_reg;
    logic              emergency_stop_reg;
    logic              fault_or_done_reg;
    logic              single_key_reg;
    logic [2:0]        warm_cnt_reg;

    // Tick divider

    wire tick_wrap = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + TICK_W'(1);
            tick_reg     <= tick_wrap;
        end
    end

    // Start-up guard

    // The conditioned inputs reset high, which reads as pressed in active-high modes.
    // Filters stay transparent until the sync chain carries the pin, and the steppers
    // stay cleared one cycle more so that the reset level never counts as an edge.
    wire warm        = warm_cnt_reg == `SIDS_WARM_CYCLES;
    wire warm_bypass = warm_cnt_reg < (`SIDS_WARM_CYCLES - 3'h1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_cnt_reg <= '0;
        end else if (!warm) begin
            warm_cnt_reg <= warm_cnt_reg + 3'h1;
        end
    end

    // Input conditioning

    wire logic_level = signal_type != `SIDS_TYPE_SWITCH;
    // Contacts that bounce at power-up are taken as they stand until one cycle before the guard ends
    wire filter_off  = logic_level || warm_bypass;

    sids_debounce #(
        .TICKS (DEBOUNCE_US)
    ) u_deb_one (
        .clk    (clk),
        .rst_n  (rst_n),
        .raw    (direction_input_one),
        .tick   (tick_reg),
        .bypass (filter_off),
        .stable (deb_one)
    );

    sids_debounce #(
        .TICKS (DEBOUNCE_US)
    ) u_deb_two (
        .clk    (clk),
        .rst_n  (rst_n),
        .raw    (direction_input_two),
        .tick   (tick_reg),
        .bypass (filter_off),
        .stable (deb_two)
    );

    sids_debounce #(
        .TICKS (DEBOUNCE_US)
    ) u_deb_halt (
        .clk    (clk),
        .rst_n  (rst_n),
        .raw    (halt_input),
        .tick   (tick_reg),
        .bypass (filter_off),
        .stable (deb_halt)
    );

    // Polarity decode

    wire active_high = (signal_polarity == `SIDS_POL_HIGH)
                    || (signal_polarity == `SIDS_POL_RISE);
    wire edge_mode   = (signal_polarity == `SIDS_POL_FALL)
                    || (signal_polarity == `SIDS_POL_RISE);

    // Pressed means the input sits at its active level
    wire pressed_one = active_high ? deb_one : !deb_one;
    wire pressed_two = active_high ? deb_two : !deb_two;
    // Halt acts on its level even in edge modes so a held button keeps the motor stopped
    wire halt_act    = active_high ? deb_halt : !deb_halt;

    wire seq_enable  = (port_input_type == `SIDS_IN_TYPE_PROG)
                    && (port_control_type == `SIDS_CTRL_PRESET)
                    && (control_method == `SIDS_METHOD_SINGLE);

    // Halt also rewinds both cycles so the next press starts fresh
    wire step_clear  = halt_act || !seq_enable || !warm;

    sids_stepper u_step_one (
        .clk        (clk),
        .rst_n      (rst_n),
        .pressed    (pressed_one),
        .level_mode (!edge_mode),
        .clear      (step_clear),
        .step       (step_one),
        .advanced   (adv_one)
    );

    sids_stepper u_step_two (
        .clk        (clk),
        .rst_n      (rst_n),
        .pressed    (pressed_two),
        .level_mode (!edge_mode),
        .clear      (step_clear),
        .step       (step_two),
        .advanced   (adv_two)
    );

    // Command selection: the input that stepped last owns the motor; input one wins when both step in the same cycle

    wire select_two = adv_one ? 1'b0 : (adv_two ? 1'b1 : last_two_reg);

    wire sids_cmd_type cmd_one =
        (step_one == SIDS_STEP_RUN_A) ? SIDS_CMD_FWD :
        (step_one == SIDS_STEP_RUN_B) ? SIDS_CMD_REV : SIDS_CMD_STOP;
    wire sids_cmd_type cmd_two =
        (step_two == SIDS_STEP_RUN_A) ? SIDS_CMD_REV :
        (step_two == SIDS_STEP_RUN_B) ? SIDS_CMD_FWD : SIDS_CMD_STOP;
    wire sids_cmd_type cmd     = select_two ? cmd_two : cmd_one;

    wire fod_next = (working_mode == `SIDS_MODE_POSITION) ? position_done : drive_fault;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_two_reg       <= 1'b0;
            run_forward_reg    <= 1'b0;
            run_reverse_reg    <= 1'b0;
            emergency_stop_reg <= 1'b0;
            fault_or_done_reg  <= 1'b0;
            single_key_reg     <= 1'b0;
        end else begin
            last_two_reg       <= !step_clear && select_two;
            run_forward_reg    <= !step_clear && (cmd == SIDS_CMD_FWD);
            run_reverse_reg    <= !step_clear && (cmd == SIDS_CMD_REV);
            emergency_stop_reg <= halt_act;
            fault_or_done_reg  <= fod_next;
            single_key_reg     <= seq_enable;
        end
    end

    assign run_forward          = run_forward_reg;
    assign run_reverse          = run_reverse_reg;
    assign emergency_stop       = emergency_stop_reg;
    assign fault_or_done_output = fault_or_done_reg;
    assign single_key_active    = single_key_reg;

    // Checks

    property p_halt_stops;
        @(posedge clk) disable iff (!rst_n)
        halt_act |=> !run_forward_reg && !run_reverse_reg && emergency_stop_reg;
    endproperty
    a_halt_stops: assert property (p_halt_stops)
        else $error("motor still commanded while halt active");

    property p_status_select;
        @(posedge clk) disable iff (!rst_n)
        (working_mode == `SIDS_MODE_POSITION) |=> fault_or_done_reg == $past(position_done);
    endproperty
    a_status_select: assert property (p_status_select)
        else $error("status line does not show completion in position mode");

    property p_disabled_idle;
        @(posedge clk) disable iff (!rst_n)
        !seq_enable |=> !run_forward_reg && !run_reverse_reg && !single_key_reg;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle)
        else $error("motor commanded while single-key operation is off");

    property p_edge_one_fwd;
        @(posedge clk) disable iff (!rst_n)
        (edge_mode && $fell(pressed_one) && step_one == SIDS_STEP_STOP_B && !step_clear)
            ##1 !step_clear |=> run_forward_reg;
    endproperty
    a_edge_one_fwd: assert property (p_edge_one_fwd)
        else $error("completed press on input one did not start forward");

    property p_edge_two_rev;
        @(posedge clk) disable iff (!rst_n)
        (edge_mode && $fell(pressed_two) && !$fell(pressed_one)
            && step_two == SIDS_STEP_STOP_B && !step_clear)
            ##1 !step_clear |=> run_reverse_reg;
    endproperty
    a_edge_two_rev: assert property (p_edge_two_rev)
        else $error("completed press on input two did not start reverse");

    property p_level_one_rev;
        @(posedge clk) disable iff (!rst_n)
        (!edge_mode && adv_one && step_one == SIDS_STEP_RUN_B && !step_clear)
            |=> run_reverse_reg && !run_forward_reg;
    endproperty
    a_level_one_rev: assert property (p_level_one_rev)
        else $error("second active period on input one did not reverse");

    property p_level_two_rev;
        @(posedge clk) disable iff (!rst_n)
        (!edge_mode && adv_two && !adv_one && step_two == SIDS_STEP_RUN_A && !step_clear)
            |=> run_reverse_reg;
    endproperty
    a_level_two_rev: assert property (p_level_two_rev)
        else $error("first active period on input two did not reverse");

    property p_high_release_stops;
        @(posedge clk) disable iff (!rst_n)
        (signal_polarity == `SIDS_POL_HIGH && $fell(deb_one) && step_one == SIDS_STEP_RUN_A
            && !last_two_reg && !adv_two)
            ##1 !adv_two |=> !run_forward_reg && !run_reverse_reg;
    endproperty
    a_high_release_stops: assert property (p_high_release_stops)
        else $error("low level on input one did not stop the motor in high mode");

    property p_warm_quiet;
        @(posedge clk) disable iff (!rst_n)
        !warm |=> !run_forward_reg && !run_reverse_reg;
    endproperty
    a_warm_quiet: assert property (p_warm_quiet)
        else $error("motor commanded before the inputs settled after reset");

    property p_one_first_fwd;
        @(posedge clk) disable iff (!rst_n)
        (adv_one && step_one == SIDS_STEP_RUN_A && !step_clear)
            |=> run_forward_reg && !run_reverse_reg;
    endproperty
    a_one_first_fwd: assert property (p_one_first_fwd)
        else $error("first step on input one did not run forward");

    property p_two_second_fwd;
        @(posedge clk) disable iff (!rst_n)
        (adv_two && !adv_one && step_two == SIDS_STEP_RUN_B && !step_clear)
            |=> run_forward_reg && !run_reverse_reg;
    endproperty
    a_two_second_fwd: assert property (p_two_second_fwd)
        else $error("third step on input two did not run forward");

    property p_enable_flag;
        @(posedge clk) disable iff (!rst_n)
        seq_enable |=> single_key_reg;
    endproperty
    a_enable_flag: assert property (p_enable_flag)
        else $error("single-key flag low although the settings enable it");

    property p_status_fault;
        @(posedge clk) disable iff (!rst_n)
        (working_mode != `SIDS_MODE_POSITION) |=> fault_or_done_reg == $past(drive_fault);
    endproperty
    a_status_fault: assert property (p_status_fault)
        else $error("status line does not show the fault outside position mode");

endmodule : sids_sequencer

// ### design/sids_stepper.sv
module sids_stepper (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              pressed,
    input  wire logic              level_mode,
    input  wire logic              clear,
    output sids_pkg::sids_step_type step,
    output logic                   advanced
);
    import sids_pkg::*;

    logic          prev_reg;
    logic          adv_reg;
    sids_step_type step_reg;
    sids_step_type step_next;

    wire press_edge   = pressed && !prev_reg;
    wire release_edge = !pressed && prev_reg;
    // Level modes step on both edges, edge modes only on a completed press
    wire advance      = release_edge || (level_mode && press_edge);

    always_comb begin
        unique case (step_reg)
            SIDS_STEP_RUN_A:  step_next = SIDS_STEP_STOP_A;
            SIDS_STEP_STOP_A: step_next = SIDS_STEP_RUN_B;
            SIDS_STEP_RUN_B:  step_next = SIDS_STEP_STOP_B;
            SIDS_STEP_STOP_B: step_next = SIDS_STEP_RUN_A;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
            step_reg <= SIDS_STEP_STOP_B;
            adv_reg  <= 1'b0;
        end else begin
            prev_reg <= pressed;
            adv_reg  <= !clear && advance;
            if (clear) begin
                step_reg <= SIDS_STEP_STOP_B;
            end else if (advance) begin
                step_reg <= step_next;
            end
        end
    end

    assign step     = step_reg;
    assign advanced = adv_reg;

    property p_level_press_runs;
        @(posedge clk) disable iff (!rst_n)
        (level_mode && !clear && press_edge && step_reg == SIDS_STEP_STOP_B)
            |=> (step_reg == SIDS_STEP_RUN_A) && adv_reg;
    endproperty
    a_level_press_runs: assert property (p_level_press_runs)
        else $error("level press from stop did not start the first direction");

    property p_edge_holds;
        @(posedge clk) disable iff (!rst_n)
        (!level_mode && !clear && !release_edge) |=> $stable(step_reg) && !adv_reg;
    endproperty
    a_edge_holds: assert property (p_edge_holds)
        else $error("edge mode step changed without a completed press");

endmodule : sids_stepper

// ### test/sids_button_model.sv
module sids_button_model (
    input  wire logic clk,
    input  wire logic press_one,
    input  wire logic press_two,
    input  wire logic press_halt,
    input  wire logic active_high,
    input  wire logic chatter,
    output logic      line_one,
    output logic      line_two,
    output logic      line_halt
);
    logic toggle_reg = 1'b0;

    // Contact bounce on the first line, only while a scenario asks for it
    always @(negedge clk) begin
        toggle_reg <= chatter ? ~toggle_reg : 1'b0;
    end

    // A released contact or idle control line sits at the inactive level
    assign line_one  = ~((press_one ^ toggle_reg) ^ active_high);
    assign line_two  = ~(press_two ^ active_high);
    assign line_halt = ~(press_halt ^ active_high);
endmodule : sids_button_model

// ### test/tb.sv
`include "sids_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sids_pkg::*;

    localparam int         DEB_US = 2;
    localparam int         LIMIT  = 20000;
    localparam logic [2:0] FWD    = 3'b100;
    localparam logic [2:0] REV    = 3'b010;
    localparam logic [2:0] STP    = 3'b000;
    localparam logic [2:0] HLT    = 3'b001;

    logic       clk               = 1'b0;
    logic       rst_n             = 1'b0;
    logic       act_one           = 1'b0;
    logic       act_two           = 1'b0;
    logic       act_halt          = 1'b0;
    logic       active_high       = 1'b0;
    logic       chatter           = 1'b0;
    logic [1:0] signal_polarity   = `SIDS_POL_LOW;
    logic [1:0] signal_type       = `SIDS_TYPE_3V3;
    logic [7:0] port_input_type   = `SIDS_IN_TYPE_PROG;
    logic [7:0] port_control_type = `SIDS_CTRL_PRESET;
    logic [7:0] control_method    = `SIDS_METHOD_SINGLE;
    logic [1:0] working_mode      = `SIDS_MODE_DUTY;
    logic       drive_fault       = 1'b0;
    logic       position_done     = 1'b0;
    wire logic  line_one;
    wire logic  line_two;
    wire logic  line_halt;
    logic       run_forward;
    logic       run_reverse;
    logic       emergency_stop;
    logic       fault_or_done_output;
    logic       single_key_active;
    int         n_mismatch        = 0;
    int         check_count       = 0;
    int         cyc               = 0;
    int         settle            = 12;

    always #20 clk = ~clk;

    sids_button_model far_u (
        .clk(clk), .press_one(act_one), .press_two(act_two), .press_halt(act_halt),
        .active_high(active_high), .chatter(chatter),
        .line_one(line_one), .line_two(line_two), .line_halt(line_halt)
    );

    sids_sequencer #(.DEBOUNCE_US(DEB_US)) dut_u (
        .clk(clk), .rst_n(rst_n),
        .direction_input_one(line_one), .direction_input_two(line_two), .halt_input(line_halt),
        .signal_polarity(signal_polarity), .signal_type(signal_type),
        .port_input_type(port_input_type), .port_control_type(port_control_type),
        .control_method(control_method), .working_mode(working_mode),
        .drive_fault(drive_fault), .position_done(position_done),
        .run_forward(run_forward), .run_reverse(run_reverse), .emergency_stop(emergency_stop),
        .fault_or_done_output(fault_or_done_output), .single_key_active(single_key_active)
    );

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check_motor(input logic [2:0] exp);
        check_count++;
        if ({run_forward, run_reverse, emergency_stop} !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {run_forward, run_reverse, emergency_stop}, exp);
        end
    endtask : check_motor

    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_flag

    task automatic act(input int which, input logic v);
        if (which == 1) act_one = v;
        else act_two = v;
        repeat (settle) @(negedge clk);
    endtask : act

    // Halt rewinds both cycles, so each scenario starts from a known step
    task automatic rewind(input logic [1:0] pol);
        signal_polarity = pol;
        active_high     = pol[0];
        act_one         = 1'b0;
        act_two         = 1'b0;
        act_halt        = 1'b1;
        repeat (settle) @(negedge clk);
        check_motor(HLT);
        act_halt = 1'b0;
        repeat (settle) @(negedge clk);
        check_motor(STP);
    endtask : rewind

    task automatic cycle(input int which, input logic edge_mode);
        logic [2:0] seq [5];
        logic [2:0] prev;
        seq[0] = (which == 1) ? FWD : REV;
        seq[1] = STP;
        seq[2] = (which == 1) ? REV : FWD;
        seq[3] = STP;
        seq[4] = seq[0];
        prev   = STP;
        for (int k = 0; k < 5; k++) begin
            if (edge_mode) begin
                act(which, 1'b1);
                check_motor(prev);
                act(which, 1'b0);
                check_motor(seq[k]);
                prev = seq[k];
            end else begin
                act(which, ~k[0]);
                check_motor(seq[k]);
            end
        end
        if (!edge_mode) act(which, 1'b0);
    endtask : cycle

    task automatic sc_halt();
        for (int p = 0; p < 4; p++) begin
            rewind(p[1:0]);
            act(1, 1'b1);
            if (p[1]) act(1, 1'b0);
            check_motor(FWD);
            act_halt = 1'b1;
            act(2, 1'b1);
            check_motor(HLT);
            act_one = 1'b0;
            act(2, 1'b0);
            act_halt = 1'b0;
            repeat (settle) @(negedge clk);
            check_motor(STP);
        end
    endtask : sc_halt

    // After a reset in high-level mode the high reset level must not count as a press
    task automatic sc_reset();
        rewind(`SIDS_POL_HIGH);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check_motor(STP);
        rst_n = 1'b1;
        repeat (settle) @(negedge clk);
        check_motor(STP);
        act(1, 1'b1);
        check_motor(FWD);
        act(1, 1'b0);
        check_motor(STP);
    endtask : sc_reset

    task automatic sc_enable();
        signal_type = `SIDS_TYPE_5V;
        rewind(`SIDS_POL_LOW);
        for (int i = 0; i < 3; i++) begin
            if (i == 0) port_input_type = 8'h03;
            if (i == 1) port_control_type = 8'h04;
            if (i == 2) control_method = 8'h00;
            act(1, 1'b1);
            check_flag(single_key_active, 1'b0);
            check_motor(STP);
            act(1, 1'b0);
            port_input_type   = `SIDS_IN_TYPE_PROG;
            port_control_type = `SIDS_CTRL_PRESET;
            control_method    = `SIDS_METHOD_SINGLE;
            repeat (3) @(negedge clk);
            check_flag(single_key_active, 1'b1);
        end
        act(1, 1'b1);
        check_motor(FWD);
        act(1, 1'b0);
    endtask : sc_enable

    task automatic sc_status();
        for (int m = 0; m < 4; m++) begin
            for (int f = 0; f < 4; f++) begin
                working_mode  = m[1:0];
                drive_fault   = f[0];
                position_done = f[1];
                repeat (2) @(negedge clk);
                check_flag(fault_or_done_output, (m == 3) ? f[1] : f[0]);
            end
        end
    endtask : sc_status

    // Switch contacts take the debounce time; a short tap or chatter must not count
    task automatic sc_switch();
        signal_type = `SIDS_TYPE_SWITCH;
        settle      = 150;
        rewind(`SIDS_POL_LOW);
        act_one = 1'b1;
        repeat (10) @(negedge clk);
        act(1, 1'b0);
        check_motor(STP);
        chatter = 1'b1;
        act_one = 1'b1;
        repeat (40) @(negedge clk);
        chatter = 1'b0;
        repeat (12) @(negedge clk);
        check_motor(STP);
        act(1, 1'b1);
        check_motor(FWD);
        act(1, 1'b0);
        check_motor(STP);
        signal_type = `SIDS_TYPE_3V3;
        settle      = 12;
    endtask : sc_switch

    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        rewind(`SIDS_POL_LOW);
        cycle(1, 1'b0);
        rewind(`SIDS_POL_LOW);
        cycle(2, 1'b0);
        rewind(`SIDS_POL_HIGH);
        cycle(1, 1'b0);
        rewind(`SIDS_POL_FALL);
        cycle(1, 1'b1);
        rewind(`SIDS_POL_FALL);
        cycle(2, 1'b1);
        rewind(`SIDS_POL_RISE);
        cycle(1, 1'b1);
        sc_reset();
        sc_halt();
        sc_enable();
        sc_status();
        sc_switch();
        print_verdict();
    end
endmodule : tb
